// ### logic/ptsro_pkg.sv
// shared constants and types for the timestamp readout register group
package ptsro_pkg;
    // register offsets inside the page
    localparam logic [4:0]  OFS_READ_SUM   = 5'h1A;
    localparam logic [4:0]  OFS_WRITE_SUM  = 5'h1B;
    localparam logic [4:0]  OFS_TX_PORT    = 5'h1C;
    localparam logic [4:0]  OFS_RX_PORT    = 5'h1D;
    localparam logic [4:0]  OFS_EV_STATE   = 5'h1E;
    localparam logic [4:0]  OFS_EV_PORT    = 5'h1F;
    localparam logic [15:0] SUM_RST        = 16'h0000;
    localparam logic [15:0] WORD_RST       = 16'h0000;
    // queue geometry and word pointers
    localparam logic [2:0]  QDEPTH         = 3'h4;
    localparam logic [1:0]  TX_LAST_WORD   = 2'h3;
    localparam logic [2:0]  RX_LAST_WORD   = 3'h5;
    localparam logic [2:0]  EV_LAST_SINGLE = 3'h3;
    localparam logic [2:0]  EV_LAST_MULT   = 3'h4;
    localparam logic [1:0]  OVF_MAX        = 2'h3;
    localparam logic [2:0]  MISS_MAX       = 3'h7;
    localparam logic [4:0]  RSV_ZERO       = 5'h00;
    // serial management framing
    localparam logic [4:0]  PHY_ADDR_DEF   = 5'h01;
    localparam logic [5:0]  PRE_ONES       = 6'h20;
    localparam logic [4:0]  HDR_LAST       = 5'h0C;
    localparam logic [4:0]  DATA_LAST      = 5'h0F;
    localparam logic [1:0]  OP_READ        = 2'h2;
    localparam logic [1:0]  OP_WRITE       = 2'h1;

    typedef enum logic [2:0] {
        SMI_PRE,
        SMI_HDR,
        SMI_TA,
        SMI_RDATA,
        SMI_WDATA
    } ptsro_smi_e;
endpackage

// ### logic/ptsro_acc_if.sv
// register access carrier between the serial slave and the register group
`timescale 1ns/10ps
interface ptsro_acc_if;
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;

    modport slave (output rd, output wr, output addr, output wdata, input rdata);
    modport regs  (input rd, input wr, input addr, input wdata, output rdata);
endinterface

// ### logic/ptsro_smi_slave.sv
// serial management slave: turns sampled frames into register strobes
`timescale 1ns/10ps
module ptsro_smi_slave #(
    parameter logic [4:0] PHY_ADDR = ptsro_pkg::PHY_ADDR_DEF
) (
    input  wire logic          sys_clk,
    input  wire logic          rstn,
    input  wire logic          mdc,
    input  wire logic          mdio_in,
    output logic               mdio_out,
    output logic               mdio_oe,
    ptsro_acc_if.slave         acc
);
    import ptsro_pkg::*;

    typedef struct packed {
        logic        mdc_s1;
        logic        mdc_s2;
        logic        mdc_d;
        logic        mdio_s1;
        logic        mdio_s2;
        ptsro_smi_e  st;
        logic [5:0]  ones;
        logic [4:0]  cnt;
        logic [12:0] hdr;
        logic [15:0] sh;
        logic        oe;
        logic        out;
        logic        rd;
        logic        wr;
    } ptsro_smi_s;

    ptsro_smi_s r;
    ptsro_smi_s next_r;
    logic       rise;
    logic       bit_in;
    logic [12:0] full;

    always_comb begin
        next_r         = r;
        next_r.rd      = 1'b0;
        next_r.wr      = 1'b0;
        next_r.mdc_s1  = mdc;
        next_r.mdc_s2  = r.mdc_s1;
        next_r.mdc_d   = r.mdc_s2;
        next_r.mdio_s1 = mdio_in;
        next_r.mdio_s2 = r.mdio_s1;
        rise   = r.mdc_s2 & ~r.mdc_d;
        bit_in = r.mdio_s2;
        full   = {r.hdr[11:0], bit_in};
        // read data is taken in the same cycle as the strobe, with the address registered alongside it
        if (r.rd) begin
            next_r.sh = acc.rdata;
        end
        if (rise) begin
            case (r.st)
                SMI_PRE: begin
                    if (bit_in) begin
                        if (r.ones != PRE_ONES) begin
                            next_r.ones = r.ones + 6'h01;
                        end
                    end else if (r.ones == PRE_ONES) begin
                        next_r.st  = SMI_HDR;
                        next_r.cnt = 5'h00;
                    end else begin
                        next_r.ones = 6'h00;
                    end
                end
                SMI_HDR: begin
                    next_r.hdr = full;
                    next_r.cnt = r.cnt + 5'h01;
                    if (r.cnt == HDR_LAST) begin
                        next_r.ones = 6'h00;
                        next_r.cnt  = 5'h00;
                        if (full[12] && full[9:5] == PHY_ADDR
                            && (full[11:10] == OP_READ || full[11:10] == OP_WRITE)) begin
                            next_r.st = SMI_TA;
                            next_r.rd = (full[11:10] == OP_READ);
                        end else begin
                            next_r.st = SMI_PRE;
                        end
                    end
                end
                SMI_TA: begin
                    next_r.cnt = r.cnt + 5'h01;
                    if (r.hdr[11:10] == OP_READ) begin
                        next_r.oe  = 1'b1;
                        next_r.out = 1'b0;
                        if (r.cnt != 5'h00) begin
                            next_r.out = r.sh[15];
                            next_r.sh  = {r.sh[14:0], 1'b0};
                            next_r.cnt = 5'h00;
                            next_r.st  = SMI_RDATA;
                        end
                    end else if (r.cnt != 5'h00) begin
                        next_r.cnt = 5'h00;
                        next_r.st  = SMI_WDATA;
                    end
                end
                SMI_RDATA: begin
                    next_r.cnt = r.cnt + 5'h01;
                    next_r.out = r.sh[15];
                    next_r.sh  = {r.sh[14:0], 1'b0};
                    if (r.cnt == DATA_LAST) begin
                        next_r.oe  = 1'b0;
                        next_r.out = 1'b0;
                        next_r.st  = SMI_PRE;
                    end
                end
                SMI_WDATA: begin
                    next_r.sh  = {r.sh[14:0], bit_in};
                    next_r.cnt = r.cnt + 5'h01;
                    if (r.cnt == DATA_LAST) begin
                        next_r.wr = 1'b1;
                        next_r.st = SMI_PRE;
                    end
                end
                default: begin
                    next_r.st = SMI_PRE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign acc.rd    = r.rd;
    assign acc.wr    = r.wr;
    assign acc.addr  = r.hdr[4:0];
    assign acc.wdata = r.sh;
    assign mdio_out  = r.out;
    assign mdio_oe   = r.oe;
endmodule

// ### logic/ptsro_regs.sv
// timestamp readout register group with checksums and stamp queues
// Notes on behaviour
// - read sum accumulates the one's complement sum of each page read data word
// - reading the read sum returns it, clears it, and does not add it
// - data read from the write sum is added into the read sum
// - write sum accumulates page write data and clears when read
// - writes to either sum register still enter the write sum
// - control frame accesses never accumulate, but their reads still clear
// - transmit stamp comes as ns low, overflow plus ns high, sec low, sec high
// - transmit and receive queues' 2-bit dropped counts saturate at three
// - receive stamp adds sequence id, then message type over source hash
// - event status reads zero when no event is queued
// - each event status read retires the entry shown by the previous status read
// - bits 10:8 give missed events for the unit, saturating at seven
// - bits 7:6 give changed low stamp words minus one
// - bit 5 is edge direction of the reported unit, 1 rising
// - bits 4:2 give lowest unit with missed events, else lowest detected unit
// - bit 1 marks coincident events; extended word then read first
// - bit 0 set when any unit detected an event
// - reserved upper status bits read zero and ignore writes
// - with coincident events, the extended word precedes the stamp words
`timescale 1ns/10ps
module ptsro_regs #(
    parameter logic [4:0] PHY_ADDR = ptsro_pkg::PHY_ADDR_DEF
) (
    input  wire logic          sys_clk,
    input  wire logic          rstn,
    input  wire logic          mdc,
    input  wire logic          mdio_in,
    output logic               mdio_out,
    output logic               mdio_oe,
    input  wire logic          page_sel_4,
    input  wire logic          cf_rd,
    input  wire logic [4:0]    cf_addr,
    output logic [15:0]        cf_rdata,
    output logic               cf_ack,
    input  wire logic          tx_push,
    input  wire logic [61:0]   tx_stamp,
    input  wire logic          rx_push,
    input  wire logic [61:0]   rx_stamp,
    input  wire logic [15:0]   rx_seq_id,
    input  wire logic [3:0]    rx_msg_type,
    input  wire logic [11:0]   rx_src_hash,
    input  wire logic          ev_push,
    input  wire logic [61:0]   ev_stamp,
    input  wire logic [15:0]   ev_unit_bits,
    input  wire logic [31:0]   ev_miss_cnt
);
    import ptsro_pkg::*;

    typedef struct packed {
        logic [15:0]       rsum;
        logic [15:0]       wsum;
        logic [3:0][63:0]  txm;
        logic [1:0]        txh;
        logic [2:0]        txc;
        logic [1:0]        txw;
        logic [1:0]        txdrop;
        logic [3:0][95:0]  rxm;
        logic [1:0]        rxh;
        logic [2:0]        rxc;
        logic [2:0]        rxw;
        logic [1:0]        rxdrop;
        logic [3:0][87:0]  evm;
        logic [1:0]        evh;
        logic [2:0]        evc;
        logic [2:0]        evw;
        logic              evp;    // head entry already shown by a status read
        logic [61:0]       evlast;
        logic [15:0]       cf_rdata;
        logic              cf_ack;
    } ptsro_regs_s;

    ptsro_regs_s r;
    ptsro_regs_s next_r;
    ptsro_acc_if acc ();

    ptsro_smi_slave #(.PHY_ADDR(PHY_ADDR)) u_smi (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .mdc      (mdc),
        .mdio_in  (mdio_in),
        .mdio_out (mdio_out),
        .mdio_oe  (mdio_oe),
        .acc      (acc.slave)
    );

    function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[15:0] + {15'h0000, s[16]};
    endfunction

    function automatic logic [1:0] sat_inc2(input logic [1:0] v);
        return (v == OVF_MAX) ? OVF_MAX : v + 2'h1;
    endfunction

    // entry layout {overflow[1:0], ns[29:0], sec[31:0]}
    function automatic logic [15:0] stamp_word(input logic [63:0] e, input logic [1:0] k);
        case (k)
            2'h0:    return e[47:32];
            2'h1:    return e[63:48];
            2'h2:    return e[15:0];
            default: return e[31:16];
        endcase
    endfunction

    function automatic logic [2:0] lowest(input logic [7:0] v);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                n = 3'(i);
            end
        end
        return n;
    endfunction

    // event entry {missed[2:0], len[1:0], rise, unit[2:0], mult, ext[15:0], stamp[61:0]}
    function automatic logic [15:0] ev_status(input logic [87:0] e);
        return {RSV_ZERO, e[87:78], 1'b1};
    endfunction

    function automatic logic [15:0] word_of(input ptsro_regs_s s, input logic [4:0] a);
        logic [63:0] et;
        logic [87:0] ee;
        logic [95:0] er;
        et = s.txm[s.txh];
        er = s.rxm[s.rxh];
        ee = s.evm[s.evh];
        case (a)
            OFS_READ_SUM:  return s.rsum;
            OFS_WRITE_SUM: return s.wsum;
            OFS_TX_PORT:   return (s.txc == 3'h0) ? WORD_RST : stamp_word(et, s.txw);
            OFS_RX_PORT: begin
                if (s.rxc == 3'h0) begin
                    return WORD_RST;
                end else if (s.rxw == RX_LAST_WORD) begin
                    return er[15:0];
                end else if (s.rxw == RX_LAST_WORD - 3'h1) begin
                    return er[31:16];
                end else begin
                    return stamp_word(er[95:32], s.rxw[1:0]);
                end
            end
            OFS_EV_STATE: return (s.evc == {2'h0, s.evp}) ? WORD_RST
                : ev_status(s.evm[s.evh + {1'b0, s.evp}]);
            OFS_EV_PORT: begin
                if (s.evc == 3'h0) begin
                    return WORD_RST;
                end else if (ee[78]) begin
                    return (s.evw == 3'h0) ? ee[77:62]
                        : stamp_word({2'h0, ee[61:0]}, 2'(s.evw - 3'h1));
                end else begin
                    return stamp_word({2'h0, ee[61:0]}, s.evw[1:0]);
                end
            end
            default: return WORD_RST;
        endcase
    endfunction

    logic        mg_rd;
    logic        mg_wr;
    logic        c_rd;
    logic        rd_any;
    logic [4:0]  rd_addr;
    logic [15:0] mg_word;
    logic [15:0] cf_word;
    logic [15:0] rd_word;
    logic [2:0]  ev_unit;
    logic [2:0]  ev_miss;
    logic [3:0]  ev_miss_raw;
    logic [7:0]  ev_det;
    logic [7:0]  ev_rise;
    logic [7:0]  ev_missed_vec;
    logic [1:0]  ev_len;
    logic        ev_mult;

    assign mg_rd   = acc.rd & page_sel_4;
    assign mg_wr   = acc.wr & page_sel_4;
    // management access wins a collision; the control frame read is dropped
    assign c_rd    = cf_rd & page_sel_4 & ~acc.rd & ~acc.wr;
    assign rd_any  = mg_rd | c_rd;
    assign rd_addr = mg_rd ? acc.addr : cf_addr;
    assign mg_word = word_of(r, acc.addr);
    assign cf_word = word_of(r, cf_addr);
    assign rd_word = mg_rd ? mg_word : cf_word;
    assign acc.rdata = page_sel_4 ? mg_word : WORD_RST;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            ev_det[i]        = ev_unit_bits[2 * i];
            ev_rise[i]       = ev_unit_bits[2 * i + 1];
            ev_missed_vec[i] = (ev_miss_cnt[4 * i +: 4] != 4'h0);
        end
        ev_mult = (ev_det & (ev_det - 8'h01)) != 8'h00;
        ev_unit = ((ev_det & ev_missed_vec) != 8'h00) ? lowest(ev_det & ev_missed_vec)
                                                     : lowest(ev_det);
        ev_miss_raw = ev_miss_cnt[4 * ev_unit +: 4];
        ev_miss = (ev_miss_raw > {1'b0, MISS_MAX}) ? MISS_MAX : ev_miss_raw[2:0];
        if (ev_stamp[31:16] != r.evlast[31:16]) begin
            ev_len = 2'h3;
        end else if (ev_stamp[15:0] != r.evlast[15:0]) begin
            ev_len = 2'h2;
        end else if (ev_stamp[61:48] != r.evlast[61:48]) begin
            ev_len = 2'h1;
        end else begin
            ev_len = 2'h0;
        end
    end

    always_comb begin
        next_r        = r;
        next_r.cf_ack = 1'b0;
        if (rd_any) begin
            case (rd_addr)
                OFS_READ_SUM:  next_r.rsum = SUM_RST;
                OFS_WRITE_SUM: next_r.wsum = SUM_RST;
                OFS_TX_PORT: begin
                    if (r.txc != 3'h0) begin
                        next_r.txw = r.txw + 2'h1;
                        if (r.txw == TX_LAST_WORD) begin
                            next_r.txh = r.txh + 2'h1;
                            next_r.txc = r.txc - 3'h1;
                            next_r.txw = 2'h0;
                        end
                    end
                end
                OFS_RX_PORT: begin
                    if (r.rxc != 3'h0) begin
                        next_r.rxw = r.rxw + 3'h1;
                        if (r.rxw == RX_LAST_WORD) begin
                            next_r.rxh = r.rxh + 2'h1;
                            next_r.rxc = r.rxc - 3'h1;
                            next_r.rxw = 3'h0;
                        end
                    end
                end
                OFS_EV_STATE: begin
                    next_r.evw = 3'h0;
                    next_r.evh = r.evh + {1'b0, r.evp};
                    next_r.evc = r.evc - {2'h0, r.evp};
                    next_r.evp = (r.evc != {2'h0, r.evp});
                end
                OFS_EV_PORT: begin
                    if (r.evc != 3'h0
                        && r.evw != (r.evm[r.evh][78] ? EV_LAST_MULT : EV_LAST_SINGLE)) begin
                        next_r.evw = r.evw + 3'h1;
                    end
                end
                default: ;
            endcase
            // read sum's own value is never folded back in
            if (mg_rd && rd_addr != OFS_READ_SUM) begin
                next_r.rsum = oc_add(r.rsum, rd_word);
            end
            if (c_rd) begin
                next_r.cf_rdata = rd_word;
                next_r.cf_ack   = 1'b1;
            end
        end
        if (mg_wr) begin
            next_r.wsum = oc_add(r.wsum, acc.wdata);
        end
        // pops above go first, so a push into a draining full queue fits
        if (tx_push) begin
            if (next_r.txc < QDEPTH) begin
                next_r.txm[2'(next_r.txh + next_r.txc[1:0])] = {r.txdrop, tx_stamp};
                next_r.txc    = next_r.txc + 3'h1;
                next_r.txdrop = 2'h0;
            end else begin
                next_r.txdrop = sat_inc2(r.txdrop);
            end
        end
        if (rx_push) begin
            if (next_r.rxc < QDEPTH) begin
                next_r.rxm[2'(next_r.rxh + next_r.rxc[1:0])] =
                    {r.rxdrop, rx_stamp, rx_seq_id, rx_msg_type, rx_src_hash};
                next_r.rxc    = next_r.rxc + 3'h1;
                next_r.rxdrop = 2'h0;
            end else begin
                next_r.rxdrop = sat_inc2(r.rxdrop);
            end
        end
        if (ev_push && ev_det != 8'h00) begin
            next_r.evlast = ev_stamp;
            if (next_r.evc < QDEPTH) begin
                next_r.evm[2'(next_r.evh + next_r.evc[1:0])] =
                    {ev_miss, ev_len, ev_rise[ev_unit], ev_unit, ev_mult,
                     ev_unit_bits, ev_stamp};
                next_r.evc = next_r.evc + 3'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign cf_rdata = r.cf_rdata;
    assign cf_ack   = r.cf_ack;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_rsum_clear: assert property (rd_any && rd_addr == OFS_READ_SUM |=> r.rsum == SUM_RST)
        else $error("read sum not cleared by its read");
    a_wsum_cross: assert property (mg_rd && rd_addr == OFS_WRITE_SUM |=>
        r.wsum == SUM_RST && r.rsum == oc_add($past(r.rsum), $past(r.wsum)))
        else $error("write sum read did not clear and cross add");
    a_wsum_accum: assert property (mg_wr |=>
        r.wsum == oc_add($past(r.wsum), $past(acc.wdata)))
        else $error("write data not added to write sum");
    a_cf_no_sum: assert property (c_rd && cf_addr != OFS_READ_SUM && cf_addr != OFS_WRITE_SUM
        |=> $stable(r.rsum) && $stable(r.wsum))
        else $error("control frame read changed a sum");
    a_ests_empty: assert property (r.evc == 3'h0 |-> word_of(r, OFS_EV_STATE) == WORD_RST)
        else $error("event status not zero while empty");
    a_ev_advance: assert property (rd_any && rd_addr == OFS_EV_STATE && r.evp
        && !ev_push |=> r.evc == $past(r.evc) - 3'h1 && r.evw == 3'h0)
        else $error("event status read did not advance queue");
    a_tx_last_pop: assert property (rd_any && rd_addr == OFS_TX_PORT && r.txc != 3'h0 && !tx_push
        && r.txw != TX_LAST_WORD |=> $stable(r.txc) && r.txw == $past(r.txw) + 2'h1)
        else $error("transmit queue moved before last word");
    a_ovf_stick: assert property (r.txdrop == OVF_MAX && !tx_push |=> r.txdrop == OVF_MAX)
        else $error("transmit overflow count lost its saturation");
    a_resv_zero: assert property ((word_of(r, OFS_EV_STATE) & 16'hF800) == 16'h0000)
        else $error("reserved status bits not zero");
    a_mult_first: assert property (r.evc != 3'h0 && r.evm[r.evh][78] && r.evw == 3'h0
        |-> word_of(r, OFS_EV_PORT) == r.evm[r.evh][77:62])
        else $error("extended word not first after coincident events");

    c_tx_pop:   cover property (rd_any && rd_addr == OFS_TX_PORT && r.txw == TX_LAST_WORD);
    c_rx_pop:   cover property (rd_any && rd_addr == OFS_RX_PORT && r.rxw == RX_LAST_WORD);
    c_ev_mult:  cover property (rd_any && rd_addr == OFS_EV_STATE && r.evm[r.evh][78]);
    c_drop_sat: cover property (r.txdrop == OVF_MAX);
endmodule

// ### bench/ptsro_host.sv
// management host model that frames reads and writes on the serial pins
`timescale 1ns/10ps
module ptsro_host (
    output logic      mdc,
    output logic      mdio_in,
    input  wire logic mdio_out,
    input  wire logic mdio_oe
);
    logic drv = 1'b1;
    logic hoe = 1'b0;
    initial mdc = 1'b1;
    // pulled-up wire, so a released line reads one
    assign mdio_in = mdio_oe ? mdio_out : (hoe ? drv : 1'b1);
    task automatic cyc(input logic b, output logic s);
        mdc = 1'b0;
        drv = b;
        #40;
        s = mdio_in;
        mdc = 1'b1;
        #40;
    endtask
    task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [45:0] hdr;
        logic        s;
        hdr = {32'hFFFFFFFF, 2'h1, op, ptsro_pkg::PHY_ADDR_DEF, ra};
        hoe = 1'b1;
        for (int i = 45; i >= 0; i--) cyc(hdr[i], s);
        hoe = (op == ptsro_pkg::OP_WRITE);
        cyc(1'b1, s);
        cyc(1'b0, s);
        // one whole word per frame, msb first
        for (int i = 15; i >= 0; i--) begin
            cyc(wd[i], s);
            rd[i] = s;
        end
        hoe = 1'b0;
        cyc(1'b1, s);
    endtask
endmodule

// ### bench/tb_ptsro_regs.sv
// self-checking bench for the timestamp readout register group
`timescale 1ns/10ps
module tb_ptsro_regs;
    import ptsro_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        mdc, mdio_in, mdio_out, mdio_oe, cf_ack;
    logic        page_sel_4 = 1'b1;
    logic        cf_rd = 1'b0;
    logic [4:0]  cf_addr = 5'h00;
    logic [15:0] cf_rdata, rv, ws;
    logic        tx_push = 1'b0, rx_push = 1'b0, ev_push = 1'b0;
    logic [61:0] tx_stamp = '0, rx_stamp = '0, ev_stamp = '0;
    logic [15:0] rx_seq_id = '0, ev_unit_bits = '0;
    logic [3:0]  rx_msg_type = 4'h0;
    logic [11:0] rx_src_hash = 12'h000;
    logic [31:0] ev_miss_cnt = '0;
    int          fails = 0, n_checks = 0;
    always #5 sys_clk = ~sys_clk;
    ptsro_host host (.mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe));
    ptsro_regs dut (.sys_clk(sys_clk), .rstn(rstn), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .page_sel_4(page_sel_4), .cf_rd(cf_rd),
        .cf_addr(cf_addr), .cf_rdata(cf_rdata), .cf_ack(cf_ack), .tx_push(tx_push),
        .tx_stamp(tx_stamp), .rx_push(rx_push), .rx_stamp(rx_stamp), .rx_seq_id(rx_seq_id),
        .rx_msg_type(rx_msg_type), .rx_src_hash(rx_src_hash), .ev_push(ev_push),
        .ev_stamp(ev_stamp), .ev_unit_bits(ev_unit_bits), .ev_miss_cnt(ev_miss_cnt));
    function automatic logic [15:0] ocs(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] t;
        t = {1'b0, a} + {1'b0, b};
        return t[15:0] + {15'h0000, t[16]};
    endfunction
    function automatic logic [61:0] st(input logic [7:0] i);
        return {6'h01, i, 8'h5A, i, 8'hC0, i, 8'h30, i};
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic mrd(input logic [4:0] a, input logic [15:0] exp);
        host.frame(OP_READ, a, 16'h0000, rv);
        chk("management read", exp, rv);
    endtask
    task automatic mwr(input logic [4:0] a, input logic [15:0] d);
        host.frame(OP_WRITE, a, d, rv);
    endtask
    task automatic cfrd(input logic [4:0] a, input logic [15:0] exp);
        @(negedge sys_clk);
        cf_rd = 1'b1;
        cf_addr = a;
        @(negedge sys_clk);
        cf_rd = 1'b0;
        chk("control frame ack", 16'h0001, {15'h0000, cf_ack});
        chk("control frame data", exp, cf_rdata);
    endtask
    task automatic pulse(input logic [2:0] m);
        @(negedge sys_clk);
        {tx_push, rx_push, ev_push} = m;
        @(negedge sys_clk);
        {tx_push, rx_push, ev_push} = 3'h0;
    endtask
    task automatic stamp_rd(input logic [4:0] a, input logic [7:0] i, input logic [1:0] ovf);
        mrd(a, {8'h5A, i});
        mrd(a, {ovf, 6'h01, i});
        mrd(a, {8'h30, i});
        mrd(a, {8'hC0, i});
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #800us;
        fails++;
        $display("CHECK FAILED run length expected finish seen hang");
        end_sim();
    end
    initial begin
        repeat (16) @(negedge sys_clk);
        rstn = 1'b1;
        mrd(OFS_TX_PORT, 16'h0000);
        mwr(OFS_EV_STATE, 16'hFFFF);
        mrd(OFS_EV_STATE, 16'h0000);
        mwr(OFS_WRITE_SUM, 16'h8001);
        mwr(OFS_READ_SUM, 16'h8002);
        ws = ocs(ocs(16'hFFFF, 16'h8001), 16'h8002);
        mrd(OFS_WRITE_SUM, ws);
        mrd(OFS_WRITE_SUM, 16'h0000);
        mrd(OFS_READ_SUM, ws);
        mrd(OFS_READ_SUM, 16'h0000);
        mwr(OFS_WRITE_SUM, 16'h1234);
        cfrd(OFS_WRITE_SUM, 16'h1234);
        mrd(OFS_WRITE_SUM, 16'h0000);
        mrd(OFS_READ_SUM, 16'h0000);
        page_sel_4 = 1'b0;
        mwr(OFS_WRITE_SUM, 16'h0F0F);
        mrd(OFS_WRITE_SUM, 16'h0000);
        page_sel_4 = 1'b1;
        mrd(OFS_WRITE_SUM, 16'h0000);
        mrd(OFS_READ_SUM, 16'h0000);
        $display("test checksums done");
        for (int i = 0; i < 8; i++) begin
            tx_stamp = st(8'(i));
            pulse(3'h4);
        end
        for (int i = 0; i < 4; i++) stamp_rd(OFS_TX_PORT, 8'(i), 2'h0);
        tx_stamp = st(8'h08);
        pulse(3'h4);
        stamp_rd(OFS_TX_PORT, 8'h08, OVF_MAX);
        mrd(OFS_TX_PORT, 16'h0000);
        $display("test transmit queue done");
        rx_stamp = st(8'h20);
        rx_seq_id = 16'hBEEF;
        rx_msg_type = 4'hB;
        rx_src_hash = 12'h5C3;
        pulse(3'h2);
        stamp_rd(OFS_RX_PORT, 8'h20, 2'h0);
        mrd(OFS_RX_PORT, 16'hBEEF);
        mrd(OFS_RX_PORT, 16'hB5C3);
        mrd(OFS_RX_PORT, 16'h0000);
        $display("test receive queue done");
        ev_stamp = st(8'h40);
        ev_unit_bits = 16'h00C4;
        ev_miss_cnt = 32'h00009000;
        pulse(3'h1);
        ev_stamp[32] = 1'b1;
        ev_unit_bits = 16'h0001;
        ev_miss_cnt = 32'h00000000;
        pulse(3'h1);
        mrd(OFS_EV_STATE, 16'h07EF);
        mrd(OFS_EV_PORT, 16'h00C4);
        mrd(OFS_EV_PORT, 16'h5A40);
        mrd(OFS_EV_PORT, 16'h0140);
        mrd(OFS_EV_STATE, 16'h0001);
        mrd(OFS_EV_PORT, 16'h5A41);
        mrd(OFS_EV_STATE, 16'h0000);
        $display("test event queue done");
        end_sim();
    end
endmodule
